// [design/record_loader_regs.svh]
// Record layout, status codes and reset values of the parameter record loader
`ifndef RECORD_LOADER_REGS_SVH
`define RECORD_LOADER_REGS_SVH

// ----------------------------------------------------------------------------
// Record identity and layout
// ----------------------------------------------------------------------------
`define REC_PARAM_NUMBER      16'h0080
`define REC_HDR_VERSION_OFS   5'h00
`define REC_HDR_BLOCKS_OFS    5'h01
`define REC_CHAN_BASE_OFS     5'h02
`define REC_BYTES_PER_CHAN    5'h02
`define REC_TOTAL_LEN         16'h0012
`define REC_HDR_VERSION       8'h01
`define REC_HDR_BLOCKS        8'h08

// ----------------------------------------------------------------------------
// Substitute value behaviour field, low byte of each channel word
// ----------------------------------------------------------------------------
`define SUBST_FIELD_LSB       0
`define SUBST_FIELD_MSB       1
`define SUBST_CODE_INVALID    2'h3

// ----------------------------------------------------------------------------
// Status bytes
// ----------------------------------------------------------------------------
`define STS_BYTE0_ERR         8'hDF
`define STS_BYTE1_ERR         8'h80
`define STS_CODE_BAD_RECORD   8'hB0
`define STS_CODE_BAD_LENGTH   8'hB1
`define STS_CODE_BAD_SLOT     8'hB2
`define STS_CODE_BAD_HEADER   8'hE0
`define STS_CODE_BAD_SUBST    8'hE1
`define STS_SUBST_DETAIL      8'h06
`define STS_UNSPEC_DETAIL     8'h00
`define STS_OK                32'h0000_0000

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CHAN_PARAM_RESET      16'h0000

`endif

// [design/record_loader_pkg.sv]
// Types shared by the parameter record loader
`default_nettype none
package record_loader_pkg;

  localparam int NUM_CHAN = 8;

  // --------------------------------------------------------------------------
  // Write request header from the controller
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rec_number;
    logic [15:0] rec_length;
    logic        slot_ok;
  } write_req_s;

  // --------------------------------------------------------------------------
  // Answer to a write request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        ok;
    logic [31:0] status;
  } write_rsp_s;

  typedef logic [NUM_CHAN-1:0][15:0] chan_params_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RECV  = 2'b01,
    ST_CHECK = 2'b11,
    ST_REPLY = 2'b10
  } load_state_e;

endpackage : record_loader_pkg
`default_nettype wire

// [design/record_staging.sv]
// Staging store for the bytes of one record write
`default_nettype none
module record_staging #(
  parameter int DEPTH = 18
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // Byte write port
  input  wire logic                 wr_en_i,
  input  wire logic [4:0]           wr_addr_i,
  input  wire logic [7:0]           wr_data_i,
  // Registered contents
  output logic      [DEPTH-1:0][7:0] bytes_o
);

  // Address port is five bits wide
  if (DEPTH < 1 || DEPTH > 32) begin : g_bad_depth
    $error("record_staging: DEPTH out of range");
  end

  wire logic in_range = (32'(wr_addr_i) < DEPTH);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bytes_o <= '0;
    end else if (wr_en_i && in_range) begin
      bytes_o[wr_addr_i] <= wr_data_i;
    end
  end

endmodule : record_staging
`default_nettype wire

// [design/parameter_record_loader.sv]
// Parameter record loader: validates a written record, applies it atomically
//
// Function
// - Reconfiguration through parameter record number 128
// - Runtime writes change selected channels only; a commit here replaces all 8 channel words
// - Restart restores configured parameter set
// - Validate all record values before acting
// - Load only fully valid records, never partial
// - Failed write keeps parameters, returns error
// - Option bit one enables, zero disables
// - Two bytes per channel at 2+2n
// - Unknown record number reports DF 80 B0
// - Wrong record length reports DF 80 B1
// - Invalid slot reports DF 80 B2
// - Bad header reports DF 80 E0
// - Invalid substitute coding reports DF 80 E1 06
`include "record_loader_regs.svh"
`default_nettype none
module parameter_record_loader
  import record_loader_pkg::*;
#(
  parameter logic [7:0] HDR_VERSION = `REC_HDR_VERSION,
  parameter logic [7:0] HDR_BLOCKS  = `REC_HDR_BLOCKS
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Configured parameter set and restart
  input  wire chan_params_t cfg_params_i,
  input  wire logic         restart_i,
  // Record write request
  input  wire logic         req_valid_i,
  input  wire write_req_s   req_i,
  output logic              req_ready_o,
  // Record data bytes
  input  wire logic         byte_valid_i,
  input  wire logic [7:0]   byte_i,
  output logic              byte_ready_o,
  // Write status
  output logic              rsp_valid_o,
  output write_rsp_s        rsp_o,
  // Active channel parameters
  output chan_params_t      chan_params_o,
  output logic              applied_o
);

  localparam int REC_LEN = int'(`REC_TOTAL_LEN);

  // One parameter block per channel word
  if (HDR_BLOCKS != 8'(NUM_CHAN)) begin : g_bad_blocks
    $error("parameter_record_loader: HDR_BLOCKS must match channel count");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  load_state_e  state_ff;
  load_state_e  nxt_state;
  write_req_s   req_ff;
  logic [15:0]  cnt_ff;
  write_rsp_s   rsp_ff;
  chan_params_t params_ff;
  logic         applied_ff;
  logic         boot_ff;

  wire logic [REC_LEN-1:0][7:0] stage_bytes;

  // --------------------------------------------------------------------------
  // Handshake decode
  // --------------------------------------------------------------------------
  wire logic req_take  = req_valid_i && (state_ff == ST_IDLE);
  wire logic byte_take = byte_valid_i && (state_ff == ST_RECV);
  wire logic last_byte = byte_take && (cnt_ff == req_ff.rec_length - 16'h0001);
  wire logic zero_len  = (req_i.rec_length == 16'h0000);

  assign req_ready_o  = (state_ff == ST_IDLE);
  assign byte_ready_o = (state_ff == ST_RECV);

  // --------------------------------------------------------------------------
  // Staging store, byte address is the record offset
  // --------------------------------------------------------------------------
  record_staging #(
    .DEPTH     (REC_LEN)
  ) u_staging (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .wr_en_i   (byte_take),
    .wr_addr_i (cnt_ff[4:0]),
    .wr_data_i (byte_i),
    .bytes_o   (stage_bytes)
  );

  // --------------------------------------------------------------------------
  // Checks over the whole staged record
  // --------------------------------------------------------------------------
  wire logic bad_record = (req_ff.rec_number != `REC_PARAM_NUMBER);
  wire logic bad_length = (req_ff.rec_length != `REC_TOTAL_LEN);
  wire logic bad_slot   = !req_ff.slot_ok;
  wire logic bad_header =
    (stage_bytes[`REC_HDR_VERSION_OFS] != HDR_VERSION) ||
    (stage_bytes[`REC_HDR_BLOCKS_OFS] != HDR_BLOCKS);

  // Channel n word at offset 2 + 2n, low byte first
  chan_params_t staged_params;
  logic [NUM_CHAN-1:0] subst_bad;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      localparam int OFS = int'(`REC_CHAN_BASE_OFS) + int'(`REC_BYTES_PER_CHAN) * g;
      assign staged_params[g] = {stage_bytes[OFS+1], stage_bytes[OFS]};
      assign subst_bad[g] =
        (stage_bytes[OFS][`SUBST_FIELD_MSB:`SUBST_FIELD_LSB] == `SUBST_CODE_INVALID);
    end
  endgenerate

  wire logic bad_subst = |subst_bad;

  // Priority: record, length, slot, header, channel fields
  logic [31:0] check_status;
  logic        check_ok;

  always_comb begin
    check_ok     = 1'b0;
    check_status = {`STS_BYTE0_ERR, `STS_BYTE1_ERR, 16'h0000};
    if (bad_record) begin
      check_status[15:0] = {`STS_CODE_BAD_RECORD, `STS_UNSPEC_DETAIL};
    end else if (bad_length) begin
      check_status[15:0] = {`STS_CODE_BAD_LENGTH, `STS_UNSPEC_DETAIL};
    end else if (bad_slot) begin
      check_status[15:0] = {`STS_CODE_BAD_SLOT, `STS_UNSPEC_DETAIL};
    end else if (bad_header) begin
      check_status[15:0] = {`STS_CODE_BAD_HEADER, `STS_UNSPEC_DETAIL};
    end else if (bad_subst) begin
      check_status[15:0] = {`STS_CODE_BAD_SUBST, `STS_SUBST_DETAIL};
    end else begin
      check_ok     = 1'b1;
      check_status = `STS_OK;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:  if (req_take) nxt_state = zero_len ? ST_CHECK : ST_RECV;
      ST_RECV:  if (last_byte) nxt_state = ST_CHECK;
      ST_CHECK: nxt_state = ST_REPLY;
      ST_REPLY: nxt_state = ST_IDLE;
    endcase
  end

  wire logic commit = (state_ff == ST_CHECK) && check_ok;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
      req_ff   <= '0;
      cnt_ff   <= 16'h0000;
      rsp_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      if (req_take) begin
        req_ff <= req_i;
        cnt_ff <= 16'h0000;
      end else if (byte_take) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      if (state_ff == ST_CHECK) begin
        rsp_ff <= '{ok: check_ok, status: check_status};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Active parameter set
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boot_ff    <= 1'b1;
      params_ff  <= {NUM_CHAN{`CHAN_PARAM_RESET}};
      applied_ff <= 1'b0;
    end else begin
      boot_ff    <= 1'b0;
      applied_ff <= commit;
      if (boot_ff || restart_i) begin
        params_ff <= cfg_params_i;
      end else if (commit) begin
        params_ff <= staged_params;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rsp_valid_o   = (state_ff == ST_REPLY);
  assign rsp_o         = rsp_ff;
  assign chan_params_o = params_ff;
  assign applied_o     = applied_ff;

endmodule : parameter_record_loader
`default_nettype wire

// [dv/record_loader_monitor.sv]
// Port checks for the parameter record loader
`default_nettype none
module record_loader_monitor
  import record_loader_pkg::*;
#(
  parameter logic [7:0] HDR_VERSION = 8'h01,
  parameter logic [7:0] HDR_BLOCKS  = 8'h08
) (
  // Clock and reset
  input wire logic         clk_i,
  input wire logic         nrst_i,
  // Watched ports
  input wire chan_params_t cfg_params_i,
  input wire logic         restart_i,
  input wire logic         req_valid_i,
  input wire write_req_s   req_i,
  input wire logic         req_ready_o,
  input wire logic         byte_ready_o,
  input wire logic         rsp_valid_o,
  input wire write_rsp_s   rsp_o,
  input wire chan_params_t chan_params_o,
  input wire logic         applied_o
);
  timeunit 1ns;
  timeprecision 1ps;
  write_req_s req_ff;
  wire logic  rec_ok = req_ff.rec_number == 16'h0080;
  wire logic  len_ok = req_ff.rec_length == 16'h0012;
  wire logic  err    = rsp_valid_o && !rsp_o.ok;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) req_ff <= '0;
    else if (req_valid_i && req_ready_o) req_ff <= req_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ok_status_a: assert property (rsp_valid_o |-> rsp_o.ok == (rsp_o.status == '0))
    else $error("ok flag wrong");
  err_prefix_a: assert property (err |-> rsp_o.status[31:16] == 16'hDF80)
    else $error("error prefix wrong");
  bad_record_a: assert property (rsp_valid_o && !rec_ok |-> rsp_o.status == 32'hDF80_B000)
    else $error("record code wrong");
  bad_length_a: assert property (rsp_valid_o && rec_ok && !len_ok
    |-> rsp_o.status == 32'hDF80_B100) else $error("length code wrong");
  bad_slot_a: assert property (rsp_valid_o && rec_ok && len_ok && !req_ff.slot_ok
    |-> rsp_o.status == 32'hDF80_B200) else $error("slot code wrong");
  hold_on_err_a: assert property (err && !$past(restart_i) |-> $stable(chan_params_o))
    else $error("params changed on error");
  apply_pulse_a: assert property (rsp_valid_o |-> applied_o == rsp_o.ok)
    else $error("applied pulse wrong");
  restart_load_a: assert property (restart_i |=> chan_params_o == $past(cfg_params_i))
    else $error("restart load wrong");
  check_reply_a: assert property ($fell(byte_ready_o) |=> rsp_valid_o)
    else $error("reply late");
  idle_after_a: assert property (rsp_valid_o |=> req_ready_o && !rsp_valid_o)
    else $error("not idle after reply");
  ok_reply_c: cover property (rsp_valid_o && rsp_o.ok);
  err_reply_c: cover property (err);
  restart_c: cover property (restart_i);
endmodule : record_loader_monitor
bind parameter_record_loader record_loader_monitor #(.HDR_VERSION(HDR_VERSION),
  .HDR_BLOCKS(HDR_BLOCKS)) u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
  .cfg_params_i(cfg_params_i), .restart_i(restart_i), .req_valid_i(req_valid_i),
  .req_i(req_i), .req_ready_o(req_ready_o), .byte_ready_o(byte_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .chan_params_o(chan_params_o),
  .applied_o(applied_o));
`default_nettype wire

// [dv/controller_model.sv]
// Controller model that writes parameter records to the loader
`default_nettype none
module controller_model
  import record_loader_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Loader answers
  input  wire logic       req_ready_i,
  input  wire logic       byte_ready_i,
  input  wire logic       rsp_valid_i,
  // Record write stream
  output logic            req_valid_o,
  output write_req_s      req_o,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // Header, then the bytes, then cycles until the reply
  task automatic write_rec(input write_req_s hdr, input logic [7:0] rec [18],
                           input bit slow, output int lat);
    @(negedge clk_i);
    req_o = hdr;
    req_valid_o = 1'b1;
    do @(posedge clk_i); while (!req_ready_i);
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_o = ~hdr;
    for (int i = 0; i < int'(hdr.rec_length); i++) begin
      if (slow && i[0]) begin
        byte_valid_o = 1'b0;
        @(negedge clk_i);
      end
      byte_o = rec[i % 18];
      byte_valid_o = 1'b1;
      do @(posedge clk_i); while (!byte_ready_i);
      @(negedge clk_i);
    end
    byte_valid_o = 1'b0;
    byte_o = ~byte_o;
    for (lat = 0; lat < 9 && !rsp_valid_i; lat++) @(negedge clk_i);
  endtask : write_rec
endmodule : controller_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the parameter record loader
`default_nettype none
module testbench
  import record_loader_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_i, nrst_i, restart_i, req_valid_i, byte_valid_i;
  logic         req_ready_o, byte_ready_o, rsp_valid_o, applied_o;
  logic [7:0]   byte_i;
  logic [7:0]   rec [18];
  chan_params_t cfg_params_i, chan_params_o, exp_par;
  write_req_s   req_i, hdr;
  write_rsp_s   rsp_o, exp_rsp;
  int           err_count, check_count, lat, bad;
  parameter_record_loader DUT (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_params_i(cfg_params_i),
    .restart_i(restart_i), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .chan_params_o(chan_params_o),
    .applied_o(applied_o));
  controller_model ctrl (.clk_i(clk_i), .req_ready_i(req_ready_o), .byte_ready_i(byte_ready_o),
    .rsp_valid_i(rsp_valid_o), .req_valid_o(req_valid_i), .req_o(req_i),
    .byte_valid_o(byte_valid_i), .byte_o(byte_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic note(string what, logic ok, logic [127:0] exp, logic [127:0] got);
    check_count++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : note
  task automatic cmp_rsp(write_rsp_s e, write_rsp_s g);
    note("rsp", g === e, e, g);
  endtask : cmp_rsp
  task automatic cmp_par(chan_params_t e, chan_params_t g);
    note("par", g === e, e, g);
  endtask : cmp_par
  task automatic cmp_bit(string w, logic e, logic g); note(w, g === e, e, g); endtask : cmp_bit
  function automatic write_rsp_s expect_rsp(write_req_s h);
    logic sub_bad;
    sub_bad = 1'b0;
    for (int c = 0; c < 8; c++) sub_bad |= rec[2 + 2 * c][1:0] == 2'h3;
    if (h.rec_number != 16'h0080) return {1'b0, 32'hDF80_B000};
    if (h.rec_length != 16'h0012) return {1'b0, 32'hDF80_B100};
    if (!h.slot_ok) return {1'b0, 32'hDF80_B200};
    if (rec[0] != 8'h01 || rec[1] != 8'h08) return {1'b0, 32'hDF80_E000};
    if (sub_bad) return {1'b0, 32'hDF80_E106};
    return {1'b1, 32'h0000_0000};
  endfunction : expect_rsp
  initial begin
    #200us;
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(25182));
    err_count = 0;
    check_count = 0;
    nrst_i = 1'b0;
    restart_i = 1'b0;
    for (int c = 0; c < 8; c++) cfg_params_i[c] = 16'($urandom);
    repeat (2) @(negedge clk_i);
    cmp_par('0, chan_params_o);
    nrst_i = 1'b1;
    @(negedge clk_i);
    exp_par = cfg_params_i;
    cmp_par(exp_par, chan_params_o);
    // Codes 0..6 each force one fault class, above 6 a clean record
    for (int k = 0; k < 60; k++) begin
      bad = (k < 7) ? k : $urandom_range(9);
      rec[0] = (bad == 3) ? 8'h00 : 8'h01;
      rec[1] = (bad == 4) ? 8'h07 : 8'h08;
      for (int i = 2; i < 18; i++) rec[i] = 8'($urandom);
      for (int c = 0; c < 8; c++) rec[2 + 2 * c][1:0] = 2'($urandom_range(2));
      if (bad == 5) rec[2 + 2 * $urandom_range(7)][1:0] = 2'h3;
      hdr.rec_number = (bad == 0) ? 16'($urandom_range(127)) : 16'h0080;
      hdr.rec_length = (bad == 1) ? 16'(k == 1 ? 0 : $urandom_range(17)) :
                       (bad == 6) ? 16'($urandom_range(24, 19)) : 16'h0012;
      hdr.slot_ok = (bad != 2);
      exp_rsp = expect_rsp(hdr);
      ctrl.write_rec(hdr, rec, 1'($urandom_range(1)), lat);
      cmp_rsp(exp_rsp, rsp_o);
      cmp_bit("latency", 1'b1, lat == 1);
      cmp_bit("applied", exp_rsp.ok, applied_o);
      if (exp_rsp.ok) begin
        for (int c = 0; c < 8; c++) exp_par[c] = {rec[3 + 2 * c], rec[2 + 2 * c]};
      end
      cmp_par(exp_par, chan_params_o);
      if (k % 10 == 9) begin
        for (int c = 0; c < 8; c++) cfg_params_i[c] = 16'($urandom);
        restart_i = 1'b1;
        @(negedge clk_i);
        restart_i = 1'b0;
        exp_par = cfg_params_i;
        cmp_par(exp_par, chan_params_o);
      end
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
